// >>> bench/oam_mac_model.sv
// Purpose: Subordinate MAC model taking frames from the sublayer.
// Assumes: Seed set once by the bench before traffic starts.
// Notes:   Ready stalls at random to exercise held descriptors.
`timescale 1ns/10ps
module oam_mac_model (
  // Clock
  input  logic clk_sys,
  // Transmit handshake
  input  logic tx_valid,
  output logic tx_ready
);
  // Random back-pressure, one stall in four cycles
  initial tx_ready = 1'b0;
  always @(posedge clk_sys) begin
    tx_ready <= ($urandom % 4) != 0;
  end
endmodule // oam_mac_model

// >>> bench/oam_sublayer_control_mux_tb_top.sv
// Purpose: Self-checking bench for the OAM sublayer control block.
// Assumes: Short info and lost-link periods via parameters.
// Notes:   Indications are scored against a queue of expected PDUs.
`timescale 1ns/10ps
module oam_sublayer_control_mux_tb_top;
  import oam_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rx_data = 0, d, sv;
  logic rx_valid = 0, rx_status_ok = 0, tx_ready, tx_valid, tx_tlv;
  logic [47:0] rx_da = 0, rx_sa = 48'h020000000099, tx_da, tx_sa;
  logic [15:0] rx_type = SLOW_TYPE, rx_flags = 0, tx_type, tx_flags;
  logic [7:0] rx_subtype = OAM_SUBTYPE, tx_subtype, tx_code;
  logic [7:0] rx_code = CODE_INFO;
  logic mcf_valid = 0;
  logic [31:0] tx_data;
  logic lost_link_done, unidir_cap, cind_valid, oind_valid, cind_seen = 0;
  logic [15:0] oind_flags;
  logic [7:0] oind_code;
  logic [31:0] oind_data;
  logic [12:0] f;
  logic [55:0] exp_q[$];
  int fails = 0, checks_done = 0, seed;
  always #25 clk_sys = ~clk_sys;
  oam_sublayer_control_mux #(.INFO_CYC(8), .LOST_CYC(20)) i_oam_sublayer_control_mux (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cind_valid, .local_pdu(), .local_stable(), .lost_link_done,
    .unidir_cap, .oind_valid, .oind_sa(), .oind_flags, .oind_code,
    .oind_data, .rx_valid, .rx_da, .rx_sa, .rx_type, .rx_subtype,
    .rx_flags, .rx_code, .rx_data, .rx_status_ok,
    .up_valid(), .up_sa(), .up_type(), .up_data(), .mcf_valid,
    .mcf_ready(), .mcf_da(48'h0), .mcf_sa(48'h0), .mcf_type(16'h0),
    .mcf_data(32'h0), .tx_valid, .tx_ready, .tx_da, .tx_sa, .tx_type,
    .tx_subtype, .tx_flags, .tx_code, .tx_data, .tx_tlv);
  oam_mac_model i_oam_mac_model (.clk_sys, .tx_valid, .tx_ready);
  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  // Wait for a taken frame of the given code
  task automatic wait_tx(input logic [7:0] c);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      if (tx_valid === 1 && tx_ready === 1 && tx_code === c) break;
    end
    check(n < 300, 1);
  endtask
  // One received frame; only good ones are expected upstream
  task automatic rx_frame(input bit ok, input bit da_ok);
    @(posedge clk_sys);
    rx_valid <= 1; rx_status_ok <= ok; rx_flags <= $urandom;
    rx_data <= $urandom; rx_da <= da_ok ? SLOW_MCAST_DA : 48'h0180c2000003;
    #1 if (ok && da_ok) exp_q.push_back({CODE_INFO, rx_flags, rx_data});
    @(posedge clk_sys);
    rx_valid <= 0; rx_data <= ~rx_data;
  endtask
  // Indication monitor
  always @(posedge clk_sys) begin
    if (cind_valid === 1) cind_seen <= 1;
    if (oind_valid === 1) begin
      if (exp_q.size() == 0) check(1, 0);
      else check({oind_code, oind_flags, oind_data}, exp_q.pop_front());
    end
  end
  // Watchdog
  initial begin
    #(50 * 20000);
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    seed = $urandom(37);
    repeat (12) @(posedge clk_sys);
    rst_n <= 1;
    rd(REG_CTRL, sv); check(sv, 0);
    rd(4'hf, sv); check(sv, 0);
    wr(REG_CTRL, 32'h2d);
    wait_tx(CODE_INFO);
    check({tx_flags[2:0], tx_tlv}, 4'b0110);
    check(tx_da, SLOW_MCAST_DA);
    check({tx_sa[SA_GROUP_BIT], tx_type, tx_subtype}, {1'b0, SLOW_TYPE, OAM_SUBTYPE});
    check(unidir_cap, 1);
    rd(REG_CTRL, sv); check(sv, 32'h2d);
    repeat (60) @(posedge clk_sys);
    check({lost_link_done, cind_seen}, 2'b11);
    for (int i = 0; i < 8; i++) rx_frame(i != 2, i != 5);
    #1 check(lost_link_done, 0);
    wr(REG_CTRL, 32'h11);
    // Let a descriptor built under the old events drain first
    repeat (8) @(posedge clk_sys);
    wait_tx(CODE_INFO);
    check(tx_flags[2:0], 3'b100);
    f = $urandom; d = $urandom;
    wr(REG_PDU_DATA, d);
    wr(REG_PDU_CMD, {11'h0, f, CODE_VAR_REQ});
    repeat (30) @(posedge clk_sys);
    rd(REG_STATUS, sv); check(sv[23:8], 16'h0102);
    wr(REG_CTRL, 32'h13);
    wr(REG_PDU_CMD, {11'h0, f, CODE_VAR_REQ});
    wait_tx(CODE_VAR_REQ);
    check({tx_flags, tx_data}, {f, 3'b100, d});
    repeat (4) @(posedge clk_sys);
    check(exp_q.size(), 0);
    test_done();
  end
endmodule // oam_sublayer_control_mux_tb_top

// >>> core/oam_pkg.sv
// Purpose: Shared constants and types of the OAM sublayer control block.
// Assumes: 20 MHz system clock, word-indexed register port.
// Notes:   Register map, field positions, codes and timing counts.
package oam_pkg;

  // Register word indices on reg_addr
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_INFO     = 4'h1;
  localparam logic [3:0] REG_PDU_CMD  = 4'h2;
  localparam logic [3:0] REG_PDU_DATA = 4'h3;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_RX_LAST  = 4'h5;

  // Control register fields
  localparam int             CTRL_W           = 14;
  localparam logic [13:0]    CTRL_RST         = 14'h0000;
  localparam int             CTRL_EN          = 0;
  localparam int             CTRL_ACTIVE      = 1;
  localparam int             CTRL_LINK_FAIL   = 2;
  localparam int             CTRL_DYING_GASP  = 3;
  localparam int             CTRL_CRITICAL    = 4;
  localparam int             CTRL_UNIDIR      = 5;
  localparam int             CTRL_SATISFIED   = 6;
  localparam int             CTRL_REM_VALID   = 7;
  localparam int             CTRL_REM_STABLE  = 8;
  localparam int             CTRL_PEER_ACTIVE = 9;
  localparam int             CTRL_MUX_LSB     = 10;
  localparam int             CTRL_PAR_LSB     = 12;

  // Multiplexer and parser actions
  localparam logic [1:0]     ACT_FWD          = 2'h0;
  localparam logic [1:0]     ACT_DISCARD      = 2'h1;
  localparam logic [1:0]     ACT_LB           = 2'h2;

  // PDU command register fields
  localparam int             CMD_CODE_LSB     = 0;
  localparam int             CMD_FLAGS_LSB    = 8;

  // Status register fields
  localparam int             STAT_PDU_LSB     = 0;
  localparam int             STAT_STABLE      = 2;
  localparam int             STAT_LOST        = 3;
  localparam int             STAT_PEND        = 4;
  localparam int             STAT_DROP_LSB    = 8;
  localparam int             STAT_REFUSED_LSB = 16;

  // Flags field bits
  localparam int             FLAG_LINK_FAULT  = 0;
  localparam int             FLAG_DYING_GASP  = 1;
  localparam int             FLAG_CRITICAL    = 2;

  // Frame constants
  localparam logic [47:0]    SLOW_MCAST_DA    = 48'h0180c2000002;
  localparam int             SA_GROUP_BIT     = 40;
  localparam logic [15:0]    SLOW_TYPE        = 16'h8809;
  localparam logic [7:0]     OAM_SUBTYPE      = 8'h03;
  localparam logic [7:0]     CODE_INFO        = 8'h00;
  localparam logic [7:0]     CODE_VAR_REQ     = 8'h02;
  localparam logic [7:0]     CODE_VAR_RSP     = 8'h03;
  localparam logic [7:0]     CODE_LB_CTL      = 8'h04;

  // Timing
  localparam int             CLK_HZ           = 20_000_000;
  localparam int             INFO_PERIOD_US   = 1000;
  localparam int             LOST_LINK_US     = 5000;
  localparam int             INFO_PERIOD_CYC  =
    INFO_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int             LOST_LINK_CYC    =
    LOST_LINK_US * (CLK_HZ / 1_000_000);
  localparam int             CNT_W            = 24;

  // Discovery transmit permission and transmit source
  typedef enum logic [1:0] {PDU_RX_INFO, PDU_LF_INFO, PDU_INFO,
                            PDU_ANY} local_pdu_e;
  typedef enum logic [1:0] {SRC_INFO, SRC_CLIENT, SRC_LOOP,
                            SRC_MCF} tx_src_e;

endpackage

// >>> core/oam_sublayer_control_mux.sv
// Purpose: OAM sublayer control, parser and multiplexer paths.
// Assumes: Frames arrive as one-cycle descriptors and leave as descriptors held until tx_ready.
// Notes:   Control parameters are register levels; PDUs leave via tx_*.
`timescale 1ns/10ps
module oam_sublayer_control_mux #(
  parameter logic [47:0] LOCAL_SA  = 48'h020000000001, // Arbitrary value
  parameter int          INFO_CYC  = oam_pkg::INFO_PERIOD_CYC,
  parameter int          LOST_CYC  = oam_pkg::LOST_LINK_CYC
) (
  // Clock and reset
  input  logic        clk_sys,
  input  logic        rst_n,
  // Register port
  input  logic [3:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  // Control indication to client
  output logic        cind_valid,
  output oam_pkg::local_pdu_e local_pdu,
  output logic        local_stable,
  output logic        lost_link_done,
  output logic        unidir_cap,
  // OAMPDU indication to client
  output logic        oind_valid,
  output logic [47:0] oind_sa,
  output logic [15:0] oind_flags,
  output logic [7:0]  oind_code,
  output logic [31:0] oind_data,
  // Received frames from the subordinate sublayer
  input  logic        rx_valid,
  input  logic [47:0] rx_da,
  input  logic [47:0] rx_sa,
  input  logic [15:0] rx_type,
  input  logic [7:0]  rx_subtype,
  input  logic [15:0] rx_flags,
  input  logic [7:0]  rx_code,
  input  logic [31:0] rx_data,
  input  logic        rx_status_ok,
  // Non-OAM frames passed to the superior sublayer
  output logic        up_valid,
  output logic [47:0] up_sa,
  output logic [15:0] up_type,
  output logic [31:0] up_data,
  // Client frames from the superior sublayer
  input  logic        mcf_valid,
  output logic        mcf_ready,
  input  logic [47:0] mcf_da,
  input  logic [47:0] mcf_sa,
  input  logic [15:0] mcf_type,
  input  logic [31:0] mcf_data,
  // Frames to the subordinate sublayer
  output logic        tx_valid,
  input  logic        tx_ready,
  output logic [47:0] tx_da,
  output logic [47:0] tx_sa,
  output logic [15:0] tx_type,
  output logic [7:0]  tx_subtype,
  output logic [15:0] tx_flags,
  output logic [7:0]  tx_code,
  output logic [31:0] tx_data,
  output logic        tx_tlv
);
  import oam_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       info;
    logic [7:0]        pdu_code;
    logic [12:0]       pdu_flags;
    logic [31:0]       pdu_data;
    logic              pdu_pend;
    logic              info_pend;
    logic              ctl_req;
    logic              lb_pend;
    logic [47:0]       lb_da;
    logic [47:0]       lb_sa;
    logic [15:0]       lb_type;
    logic [7:0]        lb_subtype;
    logic [15:0]       lb_flags;
    logic [7:0]        lb_code;
    logic [31:0]       lb_data;
    logic              tx_valid;
    logic              tx_new;
    tx_src_e           tx_src;
    logic [47:0]       tx_da;
    logic [47:0]       tx_sa;
    logic [15:0]       tx_type;
    logic [7:0]        tx_subtype;
    logic [15:0]       tx_flags;
    logic [7:0]        tx_code;
    logic [31:0]       tx_data;
    logic              tx_tlv;
    logic              mcf_ready;
    logic              oind_valid;
    logic [47:0]       oind_sa;
    logic [15:0]       oind_flags;
    logic [7:0]        oind_code;
    logic [31:0]       oind_data;
    logic              up_valid;
    logic [47:0]       up_sa;
    logic [15:0]       up_type;
    logic [31:0]       up_data;
    logic              cind_valid;
    local_pdu_e        local_pdu;
    logic              local_stable;
    logic              lost_done;
    logic [CNT_W-1:0]  info_cnt;
    logic [CNT_W-1:0]  lost_cnt;
    logic [7:0]        drop_cnt;
    logic [7:0]        refused_cnt;
    logic [31:0]       rdata;
  } st_s;

  localparam st_s ST_RST = '0;

  st_s s;
  st_s n;

  // Decoded control levels
  logic       en;
  logic       active;
  logic       peer_active;
  logic [2:0] ev;
  logic [1:0] mux_act;
  logic [1:0] par_act;
  logic       wf;
  logic       is_oam;
  logic       withhold;

  assign en          = s.ctrl[CTRL_EN];
  assign active      = s.ctrl[CTRL_ACTIVE];
  assign peer_active = s.ctrl[CTRL_PEER_ACTIVE];
  assign mux_act     = s.ctrl[CTRL_MUX_LSB +: 2];
  assign par_act     = s.ctrl[CTRL_PAR_LSB +: 2];
  assign ev = {s.ctrl[CTRL_CRITICAL], s.ctrl[CTRL_DYING_GASP],
               s.ctrl[CTRL_LINK_FAIL]};
  // Receive classification
  assign is_oam = rx_type == SLOW_TYPE && rx_subtype == OAM_SUBTYPE;
  assign wf = is_oam && rx_da == SLOW_MCAST_DA && !rx_sa[SA_GROUP_BIT];
  assign withhold = active && !peer_active &&
                    (rx_code == CODE_VAR_REQ || rx_code == CODE_LB_CTL);

  // Next-state logic for the whole block
  always_comb begin
    local_pdu_e lp;
    logic       send_ok;
    logic       permit;
    lp      = PDU_RX_INFO;
    send_ok = 1'b0;
    permit  = 1'b0;
    n            = s;
    n.tx_new     = 1'b0;
    n.oind_valid = 1'b0;
    n.up_valid   = 1'b0;
    n.ctl_req    = 1'b0;
    n.rdata      = '0;
    // Discovery state seen by the client
    if (s.ctrl[CTRL_LINK_FAIL]) begin
      lp = PDU_LF_INFO;
    end else if (!active && !s.ctrl[CTRL_REM_VALID]) begin
      lp = PDU_RX_INFO;
    end else if (s.ctrl[CTRL_SATISFIED] && s.ctrl[CTRL_REM_STABLE]) begin
      lp = PDU_ANY;
    end else begin
      lp = PDU_INFO;
    end
    n.local_pdu    = lp;
    n.local_stable = en && s.ctrl[CTRL_SATISFIED] &&
                     s.ctrl[CTRL_REM_VALID];
    send_ok = en && (lp != PDU_RX_INFO || ev != 3'h0);
    // Client PDU permission by mode
    permit = en &&
      !(!active && (s.pdu_code == CODE_VAR_REQ ||
                    s.pdu_code == CODE_LB_CTL)) &&
      !(active && !peer_active && s.pdu_code == CODE_VAR_RSP);
    // Multiplexer: one output slot, priority mcf, loop, info, client
    if (!s.tx_valid || tx_ready) begin
      n.tx_valid = 1'b0;
      if (mcf_valid && s.mcf_ready && (!en || mux_act == ACT_FWD)) begin
        n.tx_valid = 1'b1;
        n.tx_new   = 1'b1;
        n.tx_src   = SRC_MCF;
        n.tx_da    = mcf_da;
        n.tx_sa    = mcf_sa;
        n.tx_type  = mcf_type;
        n.tx_subtype = 8'h00;
        n.tx_flags = 16'h0000;
        n.tx_code  = 8'h00;
        n.tx_data  = mcf_data;
        n.tx_tlv   = 1'b0;
      end else if (s.lb_pend) begin
        n.lb_pend  = 1'b0;
        n.tx_valid = 1'b1;
        n.tx_new   = 1'b1;
        n.tx_src   = SRC_LOOP;
        n.tx_da    = s.lb_da;
        n.tx_sa    = s.lb_sa;
        n.tx_type  = s.lb_type;
        n.tx_subtype = s.lb_subtype;
        n.tx_flags = s.lb_flags;
        n.tx_code  = s.lb_code;
        n.tx_data  = s.lb_data;
        n.tx_tlv   = 1'b0;
      end else if (s.info_pend) begin
        n.info_pend = 1'b0;
        n.tx_valid  = 1'b1;
        n.tx_new    = 1'b1;
        n.tx_src    = SRC_INFO;
        n.tx_da     = SLOW_MCAST_DA;
        n.tx_sa     = LOCAL_SA;
        n.tx_type   = SLOW_TYPE;
        n.tx_subtype = OAM_SUBTYPE;
        n.tx_flags  = {11'h000, s.local_stable, !s.local_stable, ev};
        n.tx_code   = CODE_INFO;
        n.tx_data   = ev[FLAG_LINK_FAULT] ? 32'h00000000 : s.info;
        n.tx_tlv    = !ev[FLAG_LINK_FAULT];
      end else if (s.pdu_pend) begin
        n.pdu_pend = 1'b0;
        if (permit) begin
          n.tx_valid = 1'b1;
          n.tx_new   = 1'b1;
          n.tx_src   = SRC_CLIENT;
          n.tx_da    = SLOW_MCAST_DA;
          n.tx_sa    = LOCAL_SA;
          n.tx_type  = SLOW_TYPE;
          n.tx_subtype = OAM_SUBTYPE;
          n.tx_flags = {s.pdu_flags, ev};
          n.tx_code  = s.pdu_code;
          n.tx_data  = s.pdu_data;
          n.tx_tlv   = 1'b0;
        end else begin
          n.refused_cnt = s.refused_cnt + 8'h01;
        end
      end
    end
    // Periodic Information PDU timer
    if (!send_ok) begin
      n.info_cnt = '0;
    end else if (s.info_cnt == CNT_W'(INFO_CYC - 1)) begin
      n.info_cnt  = '0;
      n.info_pend = 1'b1;
    end else begin
      n.info_cnt = s.info_cnt + 1'b1;
    end
    // New control request re-evaluated one cycle after the write
    if (s.ctl_req && send_ok) begin
      n.info_pend = 1'b1;
    end
    // Lost-link timer, restarted by each accepted OAMPDU
    if (!en) begin
      n.lost_cnt  = '0;
      n.lost_done = 1'b0;
    end else if (!s.lost_done) begin
      if (s.lost_cnt == CNT_W'(LOST_CYC - 1)) begin
        n.lost_done = 1'b1;
      end else begin
        n.lost_cnt = s.lost_cnt + 1'b1;
      end
    end
    // Parser
    if (rx_valid) begin
      if (is_oam && en) begin
        if (wf && rx_status_ok) begin
          n.lost_cnt  = '0;
          n.lost_done = 1'b0;
          if (!withhold) begin
            n.oind_valid = 1'b1;
            n.oind_sa    = rx_sa;
            n.oind_flags = rx_flags;
            n.oind_code  = rx_code;
            n.oind_data  = rx_data;
          end else begin
            n.drop_cnt = s.drop_cnt + 8'h01;
          end
        end else begin
          n.drop_cnt = s.drop_cnt + 8'h01;
        end
      end else if (!en || par_act == ACT_FWD) begin
        n.up_valid = 1'b1;
        n.up_sa    = rx_sa;
        n.up_type  = rx_type;
        n.up_data  = rx_data;
      end else if (par_act == ACT_LB && !s.lb_pend) begin
        n.lb_pend    = 1'b1;
        n.lb_da      = rx_da;
        n.lb_sa      = rx_sa;
        n.lb_type    = rx_type;
        n.lb_subtype = rx_subtype;
        n.lb_flags   = rx_flags;
        n.lb_code    = rx_code;
        n.lb_data    = rx_data;
      end else begin
        n.drop_cnt = s.drop_cnt + 8'h01;
      end
    end
    // Register writes; a set here wins over the clears above
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: begin
          n.ctrl    = reg_wdata[CTRL_W-1:0];
          n.ctl_req = 1'b1;
        end
        REG_INFO: begin
          n.info    = reg_wdata;
          n.ctl_req = 1'b1;
        end
        REG_PDU_DATA: begin
          n.pdu_data = reg_wdata;
        end
        REG_PDU_CMD: begin
          n.pdu_code  = reg_wdata[CMD_CODE_LSB +: 8];
          n.pdu_flags = reg_wdata[CMD_FLAGS_LSB +: 13];
          n.pdu_pend  = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Register reads, data in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:     n.rdata = {18'h00000, s.ctrl};
        REG_INFO:     n.rdata = s.info;
        REG_PDU_CMD:  n.rdata = {11'h000, s.pdu_flags, s.pdu_code};
        REG_PDU_DATA: n.rdata = s.pdu_data;
        REG_STATUS: begin
          n.rdata[STAT_PDU_LSB +: 2]      = s.local_pdu;
          n.rdata[STAT_STABLE]            = s.local_stable;
          n.rdata[STAT_LOST]              = s.lost_done;
          n.rdata[STAT_PEND]              = s.pdu_pend;
          n.rdata[STAT_DROP_LSB +: 8]     = s.drop_cnt;
          n.rdata[STAT_REFUSED_LSB +: 8]  = s.refused_cnt;
        end
        REG_RX_LAST:  n.rdata = {8'h00, s.oind_code, s.oind_flags};
        default:      n.rdata = '0;
      endcase
    end
    // Client frame ready: discard always drains, forward needs a slot
    n.mcf_ready = (en && mux_act == ACT_DISCARD) ||
                  (!n.tx_valid && !n.lb_pend && !n.info_pend &&
                   !n.pdu_pend);
    // Indication on any change of local discovery state
    n.cind_valid = {n.local_pdu, n.local_stable, n.lost_done} !=
                   {s.local_pdu, s.local_stable, s.lost_done};
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state
  assign reg_rdata      = s.rdata;
  assign cind_valid     = s.cind_valid;
  assign local_pdu      = s.local_pdu;
  assign local_stable   = s.local_stable;
  assign lost_link_done = s.lost_done;
  assign unidir_cap     = s.ctrl[CTRL_UNIDIR];
  assign oind_valid     = s.oind_valid;
  assign oind_sa        = s.oind_sa;
  assign oind_flags     = s.oind_flags;
  assign oind_code      = s.oind_code;
  assign oind_data      = s.oind_data;
  assign up_valid       = s.up_valid;
  assign up_sa          = s.up_sa;
  assign up_type        = s.up_type;
  assign up_data        = s.up_data;
  assign mcf_ready      = s.mcf_ready;
  assign tx_valid       = s.tx_valid;
  assign tx_da          = s.tx_da;
  assign tx_sa          = s.tx_sa;
  assign tx_type        = s.tx_type;
  assign tx_subtype     = s.tx_subtype;
  assign tx_flags       = s.tx_flags;
  assign tx_code        = s.tx_code;
  assign tx_data        = s.tx_data;
  assign tx_tlv         = s.tx_tlv;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_link_fault;
    s.tx_new && s.tx_src == SRC_INFO && $past(s.ctrl[CTRL_LINK_FAIL])
      |-> s.tx_flags[FLAG_LINK_FAULT] && !s.tx_tlv && s.tx_data == '0;
  endproperty
  a_link_fault: assert property (p_link_fault)
    else $error("link fault info pdu wrong");

  property p_event_flags;
    s.tx_new && (s.tx_src == SRC_INFO || s.tx_src == SRC_CLIENT)
      |-> s.tx_flags[2:0] == {$past(s.ctrl[CTRL_CRITICAL]),
          $past(s.ctrl[CTRL_DYING_GASP]), $past(s.ctrl[CTRL_LINK_FAIL])};
  endproperty
  a_event_flags: assert property (p_event_flags)
    else $error("event flags not on pdu");

  property p_ctl_emit;
    reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_EN] &&
      reg_wdata[CTRL_DYING_GASP] |-> ##2 s.info_pend;
  endproperty
  a_ctl_emit: assert property (p_ctl_emit)
    else $error("control request did not queue info pdu");

  property p_passive_tx;
    s.tx_new && s.tx_src == SRC_CLIENT && !$past(active)
      |-> s.tx_code != CODE_VAR_REQ && s.tx_code != CODE_LB_CTL;
  endproperty
  a_passive_tx: assert property (p_passive_tx)
    else $error("passive sent forbidden pdu");

  property p_active_rsp;
    s.tx_new && s.tx_src == SRC_CLIENT && $past(active) &&
      !$past(peer_active) |-> s.tx_code != CODE_VAR_RSP;
  endproperty
  a_active_rsp: assert property (p_active_rsp)
    else $error("active answered passive peer");

  property p_rx_ok;
    s.oind_valid |-> $past(rx_valid && rx_status_ok && wf && !withhold);
  endproperty
  a_rx_ok: assert property (p_rx_ok)
    else $error("bad oampdu reached client");

  property p_cind;
    $changed({s.local_pdu, s.local_stable, s.lost_done})
      |-> s.cind_valid;
  endproperty
  a_cind: assert property (p_cind)
    else $error("state change without indication");

  property p_lost;
    $rose(s.lost_done) |-> $past(s.lost_cnt) == CNT_W'(LOST_CYC - 1);
  endproperty
  a_lost: assert property (p_lost)
    else $error("lost link done at wrong count");

  property p_own_da;
    s.tx_new && (s.tx_src == SRC_INFO || s.tx_src == SRC_CLIENT)
      |-> s.tx_da == SLOW_MCAST_DA && !s.tx_sa[SA_GROUP_BIT];
  endproperty
  a_own_da: assert property (p_own_da)
    else $error("oampdu address wrong");

  property p_mux_discard;
    mcf_valid && s.mcf_ready && en && mux_act == ACT_DISCARD
      |=> !(s.tx_new && s.tx_src == SRC_MCF);
  endproperty
  a_mux_discard: assert property (p_mux_discard)
    else $error("client frame passed discarding mux");

  property p_loop;
    rx_valid && !is_oam && en && par_act == ACT_LB && !s.lb_pend
      |=> s.lb_pend ##[0:8] (s.tx_new && s.tx_src == SRC_LOOP);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback frame not queued");

  c_lf_info: cover property (s.tx_new && s.tx_src == SRC_INFO &&
                             s.tx_flags[FLAG_LINK_FAULT]);
  c_loop:    cover property (s.tx_new && s.tx_src == SRC_LOOP);
  c_oind:    cover property (s.oind_valid);
  c_lost:    cover property ($rose(s.lost_done));

endmodule // oam_sublayer_control_mux
